// file: pkg/drl_defs.vh
// constants for the return link coder and watermark generator
`ifndef DRL_DEFS_VH
`define DRL_DEFS_VH
// clock and symbol timing
`define CLOCK_FREQ_HZ      250000000
`define SYMBOL_RATE_BPS    19200
// convolutional code, octal generators
`define FIRST_GEN_POLY     7'o171
`define SECOND_GEN_POLY    7'o133
`define CONV_STAGES        6
// kasami generator
`define KASAMI_BITS        10
`define KASAMI_LENGTH      1023
`define SEED_BITS          4
`define SEED_DEFAULT       4'h1
`define LONG_RESET         10'h001
`define SHORT_RESET        5'h01
// amplitude levels, watermark one eighth of data
`define DATA_LEVEL         12'sh400
`define MARK_SHIFT         3
// shaping filter
`define RRC_TAPS           17
`define RRC_OVERSAMPLE     4
`define RRC_ROLLOFF_PCT    20
`endif

// file: rtl/drl_baseband.v
// return link baseband: conv coder, qpsk mapping, watermark, shaping
//
// Notes on behaviour
// R1: rate half code, generators 171 and 133
// R2: no outer code, interleaver or framing
// R3: receiver decodes from any point
// R4: coded pair forms one qpsk symbol
// R5: data and symbol rate both 19.2k
// R6: rrc shaping, roll-off 0.2
// R7: 10-bit kasami, 1023 symbols long
// R8: 4-bit seed selects transmitter sequence
// R9: one watermark chip per qpsk symbol
// R10: watermark at one eighth data amplitude
// R11: watermark aligned to frame when present
// R12: extra sync sequence without frame
// R13: receiver stores one to two seconds
// R14: several kasami sequences form identity
// R15: six stage register, constraint length seven
// R16: first output in-phase, watermark before shaping
`timescale 1ns/1ps
`include "drl_defs.vh"
module drl_baseband #(
    parameter CLOCK_HZ   = `CLOCK_FREQ_HZ,
    parameter SYMBOL_BPS = `SYMBOL_RATE_BPS,
    parameter W          = 12
) (
    // clock and reset
    input  wire                clock,
    input  wire                rst,
    // user bit stream
    input  wire                bit_valid,
    input  wire                bit_data,
    output wire                bit_ready,
    // watermark setup
    input  wire [3:0]          tx_seed,
    input  wire [3:0]          sync_seed,
    input  wire                framed,
    input  wire                frame_start,
    // shaped baseband out
    output wire                sample_valid,
    output wire signed [W+3:0] i_out,
    output wire signed [W+3:0] q_out,
    // raw symbol view
    output reg                 symbol_strobe,
    output reg                 sym_x,
    output reg                 sym_y,
    output reg                 mark_chip
);
    // cycles per shaping sample; symbol = four samples, 19.2k symbols a second [R5]
    localparam integer SAMPLE_DIV = CLOCK_HZ / (SYMBOL_BPS * `RRC_OVERSAMPLE);

    reg [15:0] div_count;
    reg [1:0]  phase;
    reg [5:0]  conv;
    reg        have_bit;
    reg        held_bit;
    reg        frame_pend;
    reg signed [W-1:0] i_imp;
    reg signed [W-1:0] q_imp;

    wire sample_tick = (div_count == 16'h0000);
    wire sym_tick    = sample_tick && (phase == 2'd0);

    // seed bits named per transmitter
    wire seed_bit_low  = tx_seed[0];
    wire seed_bit_high = tx_seed[3];

    wire [6:0] first_generator_polynomial  = `FIRST_GEN_POLY;
    wire [6:0] second_generator_polynomial = `SECOND_GEN_POLY;

    // tap parity over the input bit plus six stages [R15]
    function parity7;
        input [6:0] v;
        input [6:0] g;
        begin
            parity7 = ^(v & g);
        end
    endfunction

    wire [6:0] window = {held_bit, conv};
    wire next_x = parity7(window, first_generator_polynomial);   // [R1]
    wire next_y = parity7(window, second_generator_polynomial);  // [R1]

    // one input bit taken per symbol, stream only, nothing added [R2] [R3]
    assign bit_ready = !have_bit;

    // sample clock divider and phase within symbol
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            div_count <= 16'h0000;
            phase     <= 2'd0;
        end else if (sample_tick) begin
            div_count <= SAMPLE_DIV[15:0] - 16'h0001;
            phase     <= phase + 2'd1;
        end else begin
            div_count <= div_count - 16'h0001;
        end
    end

    // input holding stage; starved symbols encode zero, keeping rate fixed
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            have_bit <= 1'b0;
            held_bit <= 1'b0;
        end else if (sym_tick) begin
            // a bit offered on the tick itself is kept for the next symbol
            have_bit <= bit_valid && !have_bit;
            held_bit <= bit_valid && !have_bit && bit_data;
        end else if (bit_valid && !have_bit) begin
            have_bit <= 1'b1;
            held_bit <= bit_data;
        end
    end

    // encoder register shifts once per coded pair [R4] [R15]
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            conv          <= 6'h00;
            sym_x         <= 1'b0;
            sym_y         <= 1'b0;
            symbol_strobe <= 1'b0;
        end else begin
            symbol_strobe <= sym_tick;
            if (sym_tick) begin
                conv  <= {held_bit, conv[5:1]};
                sym_x <= next_x;
                sym_y <= next_y;
            end
        end
    end

    // frame start held until next symbol so alignment never slips [R11]
    always @(posedge clock or posedge rst) begin
        if (rst)
            frame_pend <= 1'b0;
        else if (sym_tick)
            frame_pend <= 1'b0;                 // a start on the tick is used at once
        else if (frame_start)
            frame_pend <= 1'b1;
    end

    wire id_chip;
    wire sync_chip;
    wire id_wrap;
    wire restart = framed && sym_tick && (frame_pend || frame_start);

    // identity sequence, one chip per symbol [R7] [R8] [R9] [R14]
    kasami_gen #(.SEED_BITS(4)) id_gen (
        .clock   (clock),
        .rst     (rst),
        .step    (sym_tick),
        .restart (restart),
        .seed    ({seed_bit_high, tx_seed[2:1], seed_bit_low}),
        .chip    (id_chip),
        .wrap    (id_wrap)
    );

    // second sequence gives timing reference when unframed [R12] [R14]
    kasami_gen #(.SEED_BITS(4)) sync_gen (
        .clock   (clock),
        .rst     (rst),
        .step    (sym_tick),
        .restart (restart),
        .seed    (sync_seed),
        .chip    (sync_chip),
        .wrap    ()
    );

    // xor of the two would cancel the shared long register; sync rides quadrature
    wire mark_bit = id_chip;
    wire q_mark   = framed ? id_chip : sync_chip;

    // impulse per symbol, zero between; watermark added before shaping [R16] [R10]
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            i_imp     <= {W{1'b0}};
            q_imp     <= {W{1'b0}};
            mark_chip <= 1'b0;
        end else if (sample_tick) begin
            if (phase == 2'd1) begin
                mark_chip <= mark_bit;
                i_imp <= (sym_x ? -`DATA_LEVEL : `DATA_LEVEL)
                       + (mark_bit ? -(`DATA_LEVEL >>> `MARK_SHIFT) : (`DATA_LEVEL >>> `MARK_SHIFT));
                q_imp <= (sym_y ? -`DATA_LEVEL : `DATA_LEVEL)
                       + (q_mark ? -(`DATA_LEVEL >>> `MARK_SHIFT) : (`DATA_LEVEL >>> `MARK_SHIFT));
            end else begin
                i_imp <= {W{1'b0}};
                q_imp <= {W{1'b0}};
            end
        end
    end

    reg sample_d;
    always @(posedge clock or posedge rst) begin
        if (rst)
            sample_d <= 1'b0;
        else
            sample_d <= sample_tick;
    end
    assign sample_valid = sample_d;

    // shaping filters, in-phase and quadrature [R6]
    rrc_filter #(.W(W), .TAPS(`RRC_TAPS)) i_shape (
        .clock     (clock),
        .rst       (rst),
        .sample_en (sample_tick),
        .din       (i_imp),
        .dout      (i_out)
    );

    rrc_filter #(.W(W), .TAPS(`RRC_TAPS)) q_shape (
        .clock     (clock),
        .rst       (rst),
        .sample_en (sample_tick),
        .din       (q_imp),
        .dout      (q_out)
    );
endmodule // drl_baseband

// file: rtl/kasami_gen.v
// small-set kasami generator, 10-bit long register and 5-bit decimated register
`timescale 1ns/1ps
`include "drl_defs.vh"
module kasami_gen #(
    parameter SEED_BITS = `SEED_BITS
) (
    // clock and reset
    input  wire                 clock,
    input  wire                 rst,
    // control
    input  wire                 step,
    input  wire                 restart,
    input  wire [SEED_BITS-1:0] seed,
    // outputs
    output reg                  chip,
    output wire                 wrap
);
    reg [9:0] long_reg;
    reg [4:0] short_reg;
    reg [9:0] count;
    reg       seeded;

    // x^10+x^3+1 and the decimated x^5+x^2+1; seed loads low short bits
    wire long_fb  = long_reg[9] ^ long_reg[2];
    wire short_fb = short_reg[4] ^ short_reg[1];

    assign wrap = step && (count == 10'd1022);

    // new period restarts from seed so each transmitter owns a phase offset
    // first step after reset loads the seed, else the first period is unseeded
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            long_reg  <= `LONG_RESET;
            short_reg <= `SHORT_RESET;
            count     <= 10'h000;
            seeded    <= 1'b0;
            chip      <= 1'b0;
        end else if (restart || wrap || (step && !seeded)) begin
            long_reg  <= `LONG_RESET;
            short_reg <= {1'b1, seed};          // never all zero
            count     <= 10'h000;
            seeded    <= 1'b1;
            if (step)
                chip <= long_reg[9] ^ short_reg[4]; // load step still emits its chip
        end else if (step) begin
            long_reg  <= {long_reg[8:0], long_fb};
            short_reg <= {short_reg[3:0], short_fb};
            count     <= count + 10'h001;
            chip      <= long_reg[9] ^ short_reg[4];
        end
    end
endmodule // kasami_gen

// file: rtl/rrc_filter.v
// square-root raised-cosine shaping, fixed taps, 4 samples per symbol
`timescale 1ns/1ps
module rrc_filter #(
    parameter W    = 12,
    parameter TAPS = 17
) (
    // clock and reset
    input  wire                clock,
    input  wire                rst,
    // sample stream
    input  wire                sample_en,
    input  wire signed [W-1:0] din,
    output reg  signed [W+3:0] dout
);
    reg signed [W-1:0] line [0:TAPS-1];
    reg signed [W+17:0] acc;
    integer i;
    integer j;

    // roll-off 0.2 coefficients, q8
    function signed [9:0] coef;
        input integer k;
        begin
            case (k < 9 ? k : 16 - k)
                0: coef = 10'sh003;
                1: coef = 10'sh3fa;
                2: coef = 10'sh3f3;
                3: coef = 10'sh3fd;
                4: coef = 10'sh01c;
                5: coef = 10'sh04c;
                6: coef = 10'sh07c;
                7: coef = 10'sh0a0;
                default: coef = 10'sh0ad;
            endcase
        end
    endfunction

    always @* begin
        acc = 30'sh0;
        for (i = 0; i < TAPS; i = i + 1)
            acc = acc + line[i] * coef(i);
    end

    // shift on each output sample; zero stuffing gives the impulse train
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            for (j = 0; j < TAPS; j = j + 1)
                line[j] <= {W{1'b0}};
            dout <= {(W+4){1'b0}};
        end else if (sample_en) begin
            line[0] <= din;
            for (j = 1; j < TAPS; j = j + 1)
                line[j] <= line[j-1];
            dout <= acc[W+11:8];
        end
    end
endmodule // rrc_filter

// file: verif/drl_baseband_monitor.sv
// port assertions for the return link baseband
`timescale 1ns/1ps
module drl_baseband_monitor #(
    parameter CLOCK_HZ   = 307200,
    parameter SYMBOL_BPS = 19200
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // watched ports
    input wire bit_valid,
    input wire bit_ready,
    input wire sample_valid,
    input wire symbol_strobe,
    input wire sym_x,
    input wire sym_y,
    input wire mark_chip
);
    localparam int SDIV = CLOCK_HZ / (SYMBOL_BPS * 4);
    localparam int SYMC = SDIV * 4;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // strobe must stay quiet for a good stretch after each pulse
    sequence quiet8;
        (!symbol_strobe) [*8];
    endsequence
    a_strobe_pulse: assert property (symbol_strobe |-> ##1 quiet8) else $error("strobe not a pulse");
    a_strobe_period: assert property (symbol_strobe |-> ##SYMC symbol_strobe) else $error("symbol period");
    a_pair_hold: assert property (!symbol_strobe |-> $stable({sym_x, sym_y})) else $error("pair moved");
    a_mark_hold: assert property ($changed(mark_chip) |-> sample_valid && $past(symbol_strobe, SDIV)) else $error("chip moved");
    a_sample_pulse: assert property (sample_valid |=> !sample_valid) else $error("sample not a pulse");
    a_sample_period: assert property (sample_valid |-> ##SDIV sample_valid) else $error("sample period");
    a_ready_refuse: assert property (bit_valid && bit_ready |=> !bit_ready) else $error("second bit taken");
    a_ready_return: assert property (!bit_ready |-> ##[1:SYMC] bit_ready) else $error("ready stuck low");
endmodule // drl_baseband_monitor

bind drl_baseband drl_baseband_monitor #(.CLOCK_HZ(CLOCK_HZ), .SYMBOL_BPS(SYMBOL_BPS)) u_drl_baseband_monitor (
    .clock(clock), .rst(rst), .bit_valid(bit_valid), .bit_ready(bit_ready), .sample_valid(sample_valid),
    .symbol_strobe(symbol_strobe), .sym_x(sym_x), .sym_y(sym_y), .mark_chip(mark_chip));

// file: verif/qpsk_sink.sv
// qpsk modulator model: takes coded pairs as signs, tallies samples
`timescale 1ns/1ps
module qpsk_sink (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // symbol and sample view
    input  wire       symbol_strobe,
    input  wire       sym_x,
    input  wire       sym_y,
    input  wire       sample_valid,
    // tallies
    output integer    n_sym,
    output integer    n_samp,
    output reg  [1:0] signs
);
    // joins the stream anywhere, no frame alignment needed
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            n_sym <= 0;
            n_samp <= 0;
            signs <= 2'h0;
        end else begin
            if (symbol_strobe) begin
                n_sym <= n_sym + 1;
                signs <= {sym_x, sym_y};
            end
            if (sample_valid) n_samp <= n_samp + 1;
        end
    end
endmodule // qpsk_sink

// file: verif/tb_top.sv
// testbench: coded pairs, idle symbols, watermark period and seed
`timescale 1ns/1ps
`include "drl_defs.vh"
module tb_top;
    reg            clock = 1'b0;
    reg            rst = 1'b1;
    reg            bit_valid = 1'b0;
    reg            bit_data = 1'b0;
    reg  [3:0]     tx_seed = `SEED_DEFAULT;
    reg            framed = 1'b0;
    reg            frame_start = 1'b0;
    wire           bit_ready, sample_valid, symbol_strobe, sym_x, sym_y, mark_chip;
    wire [15:0]    i_out, q_out;
    wire [1:0]     signs;
    integer        n_sym, n_samp, i, bad, ones;
    integer        n_fail = 0;
    integer        checks = 0;
    reg  [5:0]     sr;
    reg            chips [0:2045];
    always #2 clock = ~clock;
    // short divider: four cycles a sample, sixteen a symbol
    drl_baseband #(.CLOCK_HZ(307200), .SYMBOL_BPS(19200)) u_drl_baseband (.clock(clock), .rst(rst),
        .bit_valid(bit_valid), .bit_data(bit_data), .bit_ready(bit_ready), .tx_seed(tx_seed),
        .sync_seed(4'h3), .framed(framed), .frame_start(frame_start), .sample_valid(sample_valid), .i_out(i_out),
        .q_out(q_out), .symbol_strobe(symbol_strobe), .sym_x(sym_x), .sym_y(sym_y), .mark_chip(mark_chip));
    qpsk_sink u_qpsk_sink (.clock(clock), .rst(rst), .symbol_strobe(symbol_strobe), .sym_x(sym_x),
        .sym_y(sym_y), .sample_valid(sample_valid), .n_sym(n_sym), .n_samp(n_samp), .signs(signs));
    task stop_test;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp, input string what);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0s expected %0h seen %0h", what, exp, got);
            end
        end
    endtask
    // bounded wait; strobe seen is the value held before this edge
    task wait_strobe;
        integer k;
        begin
            k = 0;
            @(posedge clock);
            while (symbol_strobe !== 1'b1 && k < 40) begin
                @(posedge clock);
                k = k + 1;
            end
            if (symbol_strobe !== 1'b1) begin
                n_fail = n_fail + 1;
                $display("MISMATCH symbol_strobe expected 1 seen 0");
                stop_test;
            end
        end
    endtask
    task do_reset(input [3:0] seed);
        begin
            rst <= 1'b1;
            tx_seed <= seed;
            sr = 6'h00;
            repeat (12) @(posedge clock);
            rst <= 1'b0;
            wait_strobe;
        end
    endtask
    // one symbol; hold above one keeps valid up into the refused cycles
    task send_sym(input offer, input b, input integer hold);
        reg x, y;
        reg [6:0] v;
        begin
            if (offer) begin
                bit_valid <= 1'b1;
                bit_data <= b;
                repeat (hold) @(posedge clock);
                bit_valid <= 1'b0;
            end
            v = {offer & b, sr};
            x = ^(v & `FIRST_GEN_POLY);
            y = ^(v & `SECOND_GEN_POLY);
            sr = v[6:1];
            wait_strobe;
            check(sym_x, x, "sym_x");
            check(sym_y, y, "sym_y");
            @(posedge clock);
            check(signs, {x, y}, "signs");
        end
    endtask
    task t_code;
        reg [15:0] pat;
        begin
            pat = 16'hb4e1;
            for (i = 0; i < 16; i = i + 1) send_sym(1'b1, pat[i], (i == 5) ? 3 : 1);
            for (i = 0; i < 7; i = i + 1) send_sym(1'b0, 1'b0, 1);
        end
    endtask
    // first strobe after reset shows the reset chip, so skip one more symbol
    task t_mark;
        begin
            wait_strobe;
            for (i = 0; i < 2046; i = i + 1) begin
                wait_strobe;
                chips[i] = mark_chip;
            end
            bad = 0;
            ones = 0;
            for (i = 0; i < 1023; i = i + 1) begin
                if (chips[i] !== chips[i + 1023]) bad = bad + 1;
                if (chips[i] === 1'b1) ones = ones + 1;
            end
            check(bad, 0, "chip period");
            check(ones > 100 && ones < 923, 1, "chip balance");
            // all-zero pairs: positive impulses of 0x400 plus or minus one eighth
            check($signed(i_out) > 740 && $signed(i_out) < 1070, 1, "i_out level");
            check($signed(q_out) > 740 && $signed(q_out) < 1070, 1, "q_out level");
        end
    endtask
    // frame start reloads the identity sequence from its seeded phase
    task t_frame;
        begin
            tx_seed <= `SEED_DEFAULT;
            framed <= 1'b1;
            frame_start <= 1'b1;
            @(posedge clock);
            frame_start <= 1'b0;
            repeat (2) wait_strobe;
            bad = 0;
            for (i = 0; i < 64; i = i + 1) begin
                wait_strobe;
                if (mark_chip !== chips[i]) bad = bad + 1;
            end
            check(bad, 0, "frame restart");
        end
    endtask
    task t_seed;
        begin
            do_reset(4'h6);
            wait_strobe;
            bad = 0;
            for (i = 0; i < 1023; i = i + 1) begin
                wait_strobe;
                if (mark_chip !== chips[i]) bad = bad + 1;
            end
            check(bad != 0, 1, "seed differs");
        end
    endtask
    initial begin
        do_reset(`SEED_DEFAULT);
        t_mark;
        t_code;
        check((n_samp - 4 * n_sym) > -8 && (n_samp - 4 * n_sym) < 8, 1, "samples");
        t_seed;
        t_frame;
        stop_test;
    end
endmodule // tb_top
